// ===== dv/cfr_channel_setup_regs_asserts.sv
// cfr_channel_setup_regs_asserts: port checks on channel 0 of the setup bank
// assumes it is bound onto cfr_channel_setup_regs; other channels share its logic
`timescale 1ns/10ps
`default_nettype none
module cfr_channel_setup_regs_asserts #(
  parameter int NUM_CHANNELS = 4
) (
  input wire logic                       ref_clk,
  input wire logic                       reset_n,
  input wire logic [cfr_pkg::ADDR_W-1:0] regAddr,
  input wire logic [cfr_pkg::REG_W-1:0]  regWrData,
  input wire logic                       regWrite,
  input wire logic                       regRead,
  input wire logic [cfr_pkg::REG_W-1:0]  regRdData,
  input wire logic [3:0]                 chanFunc [NUM_CHANNELS],
  input wire logic [2:0]                 chanRange [NUM_CHANNELS],
  input wire logic [1:0]                 chanRate [NUM_CHANNELS],
  input wire logic                       chanGndTie [NUM_CHANNELS],
  input wire logic [1:0]                 chanInSel [NUM_CHANNELS],
  input wire logic                       chanConvOn [NUM_CHANNELS],
  input wire logic [3:0]                 chanDinSink [NUM_CHANNELS],
  input wire logic                       funcWritePulse [NUM_CHANNELS]
);
  import cfr_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // channel 0 write strobes and last cycle's write data
  wire logic  fw = regWrite && regAddr == ADDR_FUNC0;
  wire logic  cw = regWrite && regAddr == ADDR_CONV0;
  logic [15:0] wdQ;
  always_ff @(posedge ref_clk) wdQ <= regWrData;
  property p_nop; regRead && regAddr == ADDR_NOP |=> regRdData == NOP_VALUE; endproperty
  a_nop: assert property (p_nop) else $error("no-op read not zero");
  property p_func; fw |=> chanFunc[0] == (wdQ[3:0] > 4'h8 ? 4'h0 : wdQ[3:0]); endproperty
  a_func: assert property (p_func) else $error("function decode wrong");
  property p_gtie; fw |=> !chanGndTie[0]; endproperty
  a_gtie: assert property (p_gtie) else $error("ground tie kept");
  property p_sink; fw |=> chanDinSink[0] == 4'h0; endproperty
  a_sink: assert property (p_sink) else $error("sink not cleared");
  property p_pulse; funcWritePulse[0] == $past(fw); endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse wrong");
  property p_conv; chanConvOn[0]; endproperty
  a_conv: assert property (p_conv) else $error("converter off");
  property p_range; cw |=> chanRange[0] == (wdQ[7:5] > 3'h3 ? 3'h0 : wdQ[7:5]); endproperty
  a_range: assert property (p_range) else $error("range wrong");
  property p_insel; cw |=> chanInSel[0] == (wdQ[1:0] > 2'h1 ? 2'h2 : wdQ[1:0]); endproperty
  a_insel: assert property (p_insel) else $error("input select wrong");
  property p_rate; cw |=> chanRate[0] == {1'b0, wdQ[4:3] == 2'h1}; endproperty
  a_rate: assert property (p_rate) else $error("rate wrong");
endmodule
`default_nettype wire

// ===== dv/cfr_host_model.sv
// cfr_host_model: host side of the register strobe port
// assumes one request at a time; the bank never stalls
`timescale 1ns/10ps
`default_nettype none
module cfr_host_model (
  input  wire logic                       ref_clk,
  output var  logic [cfr_pkg::ADDR_W-1:0] regAddr,
  output var  logic [cfr_pkg::REG_W-1:0]  regWrData,
  output var  logic                       regWrite,
  output var  logic                       regRead,
  input  wire logic [cfr_pkg::REG_W-1:0]  regRdData
);
  import cfr_pkg::*;
  // idle bus from time zero
  initial begin
    regAddr = '0;
    regWrData = '0;
    regWrite = 1'b0;
    regRead = 1'b0;
  end
  // released lines are inverted so stale values cannot pass for data
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    regWrData <= ~d;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1 d = regRdData;
  endtask
  // a function change always passes through high impedance first
  task automatic setFunc(input int ch, input logic [15:0] d);
    wr(ADDR_FUNC0 + 7'(ch), 16'h0000);
    wr(ADDR_FUNC0 + 7'(ch), d);
  endtask
endmodule
`default_nettype wire

// ===== dv/tb_channel_function_adc_setup_regs.sv
// tb_channel_function_adc_setup_regs: self-checking bench for the setup bank
// assumes the host model drives the bus; the bench keeps an integer model
`timescale 1ns/10ps
`default_nettype none
module tb_channel_function_adc_setup_regs;
  import cfr_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [6:0]  regAddr;
  logic [15:0] regWrData, regRdData, rdv, d;
  logic        regWrite, regRead;
  logic [3:0]  chanFunc [4], chanDinSink [4];
  logic [2:0]  chanRange [4];
  logic [1:0]  chanRate [4], chanInSel [4];
  logic        chanGndTie [4], chanConvOn [4], funcWritePulse [4];
  int          fails = 0, tests_run = 0, e;
  int          fn [4], cv [4], dn [4];
  cfr_channel_setup_regs dut_u (.*);
  cfr_host_model host_u (.*);
  always #20 ref_clk = ~ref_clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // model update; a function write also clears ground tie and sink current
  task automatic mupd(input int a, input logic [15:0] v);
    if (a >= 1 && a <= 4) begin
      fn[a-1] = v & FUNC_MASK;
      cv[a-1] &= ~32'h4;
      dn[a-1] &= ~32'h3C0;
    end
    else if (a >= 5 && a <= 8) cv[a-5] = v & CONV_MASK;
    else if (a >= 9 && a <= 12) dn[a-9] = v & DIN_MASK;
  endtask
  task automatic mwr(input int a, input logic [15:0] v);
    host_u.wr(7'(a), v);
    mupd(a, v);
  endtask
  // reads every place up to one unmapped word, then every decoded output
  task automatic chkAll();
    for (int a = 0; a < 14; a++) begin
      host_u.rd(7'(a), rdv);
      e = a == 0 || a > 12 ? 0 : a < 5 ? fn[a-1] : a < 9 ? cv[a-5] : dn[a-9];
      chk(rdv, 16'(e), "readback");
    end
    for (int c = 0; c < 4; c++) begin
      chk(16'(chanFunc[c]), 16'(fn[c] > 8 ? 0 : fn[c]), "func");
      chk(16'(chanRange[c]), 16'(cv[c][7:5] > 3 ? 0 : cv[c][7:5]), "range");
      chk(16'(chanRate[c]), 16'(cv[c][4:3] == 1), "rate");
      chk(16'(chanGndTie[c]), 16'(cv[c][2]), "gndtie");
      chk(16'(chanInSel[c]), 16'(cv[c][1:0] > 1 ? 2 : cv[c][1:0]), "insel");
      chk(16'(chanConvOn[c]), 16'h0001, "convon");
      chk(16'(chanDinSink[c]), 16'(dn[c][9:6]), "sink");
    end
  endtask
  task automatic doReset();
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    foreach (fn[i]) begin
      fn[i] = 0;
      cv[i] = 0;
      dn[i] = DIN_RESET;
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    void'($urandom(94));
    doReset();
    chkAll();
    $display("reset values test done");
    // every function code, with ground tie and sink preset beforehand
    for (int k = 0; k < 16; k++) begin
      mwr(5 + k % 4, 16'($urandom) | 16'h0004);
      mwr(9 + k % 4, 16'($urandom) | 16'h03C0);
      d = 16'(k) | (16'($urandom) & 16'hFFF0);
      host_u.setFunc(k % 4, d);
      mupd(1 + k % 4, d);
      chkAll();
    end
    $display("function codes test done");
    // every range, rate and input select code
    for (int k = 0; k < 8; k++) begin
      mwr(5 + k % 4, (16'($urandom) & 16'hFF04) | 16'(k << 5 | (k % 4) << 3 | k % 4));
      chkAll();
    end
    $display("converter config test done");
    mwr(0, 16'h0000);
    mwr(0, 16'($urandom));
    mwr(13, 16'($urandom));
    chkAll();
    $display("no-op and unmapped test done");
    doReset();
    chkAll();
    $display("second reset test done");
    results();
  end
  // watchdog well past the expected run length
  initial begin
    #(40 * 20000);
    fails++;
    results();
  end
endmodule
bind cfr_channel_setup_regs cfr_channel_setup_regs_asserts #(.NUM_CHANNELS(NUM_CHANNELS)) chk_u (.*);
`default_nettype wire

// ===== src/cfr_channel_setup_regs.sv
// cfr_channel_setup_regs: no-op, per-channel function and converter config bank
// assumes a host driving a one-cycle strobe port; read data valid the next cycle
`timescale 1ns/10ps
`default_nettype none
module cfr_channel_setup_regs #(
  parameter int NUM_CHANNELS = cfr_pkg::NUM_CH
) (
  input  wire logic                      ref_clk,
  input  wire logic                      reset_n,
  input  wire logic [cfr_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [cfr_pkg::REG_W-1:0]  regWrData,
  input  wire logic                      regWrite,
  input  wire logic                      regRead,
  output logic      [cfr_pkg::REG_W-1:0]  regRdData,
  output logic      [3:0]                chanFunc     [NUM_CHANNELS],
  output logic      [2:0]                chanRange    [NUM_CHANNELS],
  output logic      [1:0]                chanRate     [NUM_CHANNELS],
  output logic                           chanGndTie   [NUM_CHANNELS],
  output logic      [1:0]                chanInSel    [NUM_CHANNELS],
  output logic                           chanConvOn   [NUM_CHANNELS],
  output logic      [3:0]                chanDinSink  [NUM_CHANNELS],
  output logic                           funcWritePulse [NUM_CHANNELS]
);
  import cfr_pkg::*;

  // elaboration-time guard: the address map has room for exactly four channels
  if (NUM_CHANNELS != NUM_CH) begin : gBadCount
    $error("cfr_channel_setup_regs: only four channels fit the address map");
  end

  logic [REG_W-1:0] funcReg [NUM_CHANNELS];
  logic [REG_W-1:0] convReg [NUM_CHANNELS];
  logic [REG_W-1:0] dinReg  [NUM_CHANNELS];
  logic [REG_W-1:0] rdData_next;
  logic             funcWr  [NUM_CHANNELS];
  logic             convWr  [NUM_CHANNELS];
  logic             dinWr   [NUM_CHANNELS];

  // true when addr hits the channel slot of a four-register group
  function automatic logic hitSlot(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] base,
                                   input int                ch);
    hitSlot = (addr == base + ADDR_W'(ch));
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_CHANNELS; g++) begin : gChan
      cfr_pkg::cfr_func_t  funcDec;
      cfr_pkg::cfr_range_t rangeDec;
      cfr_pkg::cfr_rate_t  rateDec;
      cfr_pkg::cfr_insel_t inSelDec;

      assign funcWr[g] = regWrite && hitSlot(regAddr, ADDR_FUNC0, g);
      assign convWr[g] = regWrite && hitSlot(regAddr, ADDR_CONV0, g);
      assign dinWr[g]  = regWrite && hitSlot(regAddr, ADDR_DIN0, g);

      // function selector; only the low nibble is stored
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          funcReg[g] <= FUNC_RESET;
        end else if (funcWr[g]) begin
          funcReg[g] <= regWrData & FUNC_MASK;
        end
      end

      // converter config; a function write clears the ground tie and wins
      // over a same-cycle config write, which cannot occur on this port anyway
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          convReg[g] <= CONV_RESET;
        end else if (funcWr[g]) begin
          convReg[g] <= convReg[g] & ~GTIE_FIELD;
        end else if (convWr[g]) begin
          convReg[g] <= regWrData & CONV_MASK;
        end
      end

      // digital input config shadow: only the sink field is acted on here
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          dinReg[g] <= DIN_RESET;
        end else if (funcWr[g]) begin
          dinReg[g] <= dinReg[g] & ~SINK_FIELD;
        end else if (dinWr[g]) begin
          dinReg[g] <= regWrData & DIN_MASK;
        end
      end

      // registered pulse lets the analog side see a fresh function write
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          funcWritePulse[g] <= 1'b0;
        end else begin
          funcWritePulse[g] <= funcWr[g];
        end
      end

      cfr_func_decode uFunc (
        .rawCode    (funcReg[g][3:0]),
        .func       (funcDec),
        .convActive (chanConvOn[g])
      );

      cfr_conv_decode uConv (
        .cfgWord   (convReg[g]),
        .range     (rangeDec),
        .rate      (rateDec),
        .groundTie (chanGndTie[g]),
        .inSel     (inSelDec)
      );

      assign chanFunc[g]    = funcDec;
      assign chanRange[g]   = rangeDec;
      assign chanRate[g]    = rateDec;
      assign chanInSel[g]   = inSelDec;
      assign chanDinSink[g] = dinReg[g][SINK_LSB +: 4];
    end
  endgenerate

  // read mux; no-op and unmapped addresses read zero
  always_comb begin
    rdData_next = '0;
    if (regAddr == ADDR_NOP) begin
      rdData_next = NOP_VALUE;
    end
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      if (hitSlot(regAddr, ADDR_FUNC0, c)) begin
        rdData_next = funcReg[c];
      end
      if (hitSlot(regAddr, ADDR_CONV0, c)) begin
        rdData_next = convReg[c];
      end
      if (hitSlot(regAddr, ADDR_DIN0, c)) begin
        rdData_next = dinReg[c];
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData <= '0;
    end else if (regRead) begin
      regRdData <= rdData_next;
    end else begin
      regRdData <= '0;
    end
  end
  // note: writes to the no-op address touch no register
  // switching functions via high impedance is left to the host
endmodule
`default_nettype wire

// ===== src/cfr_conv_decode.sv
// cfr_conv_decode: decodes a converter config word into range, rate and input
// assumes the word comes from the converter config register
`timescale 1ns/10ps
`default_nettype none
module cfr_conv_decode (
  input  wire logic [15:0]        cfgWord,
  output cfr_pkg::cfr_range_t     range,
  output cfr_pkg::cfr_rate_t      rate,
  output logic                    groundTie,
  output cfr_pkg::cfr_insel_t     inSel
);
  import cfr_pkg::*;

  // range: undefined codes act as the 0 to 10 V range
  always_comb begin
    unique case (cfgWord[RANGE_LSB +: 3])
      3'h1:    range = RG_2V5_EXT;
      3'h2:    range = RG_2V5_LOOP;
      3'h3:    range = RG_BIPOLAR;
      default: range = RG_0_10V;
    endcase
  end

  // rate only steers channel conversions; diagnostics have their own control
  always_comb begin
    rate = cfgWord[RATE_LSB +: 2] == 2'h1 ? RT_FAST_4K8 : RT_REJECT_20;
  end

  // input node: anything undefined routes the terminal pair
  always_comb begin
    unique case (cfgWord[INSEL_LSB +: 2])
      2'h0:    inSel = IS_POS_GND;
      2'h1:    inSel = IS_SENSE_RES;
      default: inSel = IS_TERMINALS;
    endcase
  end

  assign groundTie = cfgWord[GTIE_BIT];
endmodule
`default_nettype wire

// ===== src/cfr_func_decode.sv
// cfr_func_decode: turns a raw channel function code into a defined function
// assumes the code comes straight from the function register
`timescale 1ns/10ps
`default_nettype none
module cfr_func_decode (
  input  wire logic [3:0]         rawCode,
  output cfr_pkg::cfr_func_t      func,
  output logic                    convActive
);
  import cfr_pkg::*;

  // unknown codes fall back to high impedance
  always_comb begin
    unique case (rawCode)
      4'h0: func = FN_HIGH_Z;
      4'h1: func = FN_VOUT_MEAS;
      4'h2: func = FN_IOUT_MEAS;
      4'h3: func = FN_VIN;
      4'h4: func = FN_IIN_EXT;
      4'h5: func = FN_IIN_LOOP;
      4'h6: func = FN_RES_MEAS;
      4'h7: func = FN_DIN_LOGIC;
      4'h8: func = FN_DIN_LOOP;
      default: func = FN_HIGH_Z;
    endcase
  end

  // converter stays usable in every function, high impedance included
  assign convActive = 1'b1;
endmodule
`default_nettype wire

// ===== src/cfr_pkg.sv
// cfr_pkg: register map, field layouts and encodings for the channel setup bank
// assumes a 16-bit register word reached over a plain strobe port
package cfr_pkg;
  localparam int          REG_W       = 16;
  localparam int          ADDR_W      = 7;
  localparam int          NUM_CH      = 4;
  localparam logic [6:0]  ADDR_NOP    = 7'h00;
  localparam logic [6:0]  ADDR_FUNC0  = 7'h01;
  localparam logic [6:0]  ADDR_CONV0  = 7'h05;
  localparam logic [6:0]  ADDR_DIN0   = 7'h09;
  localparam logic [15:0] NOP_VALUE   = 16'h0000;
  localparam logic [15:0] FUNC_RESET  = 16'h0000;
  localparam logic [15:0] CONV_RESET  = 16'h0000;
  localparam logic [15:0] DIN_RESET   = 16'h000B;
  localparam logic [15:0] FUNC_MASK   = 16'h000F;
  localparam logic [15:0] CONV_MASK   = 16'h00FF;
  localparam logic [15:0] DIN_MASK    = 16'h73FF;
  localparam int          RANGE_LSB   = 5;
  localparam int          RATE_LSB    = 3;
  localparam int          GTIE_BIT    = 2;
  localparam int          INSEL_LSB   = 0;
  localparam int          SINK_LSB    = 6;
  localparam logic [15:0] SINK_FIELD  = 16'h03C0;
  localparam logic [15:0] GTIE_FIELD  = 16'h0004;

  typedef enum logic [3:0] {
    FN_HIGH_Z     = 4'h0,
    FN_VOUT_MEAS  = 4'h1,
    FN_IOUT_MEAS  = 4'h2,
    FN_VIN        = 4'h3,
    FN_IIN_EXT    = 4'h4,
    FN_IIN_LOOP   = 4'h5,
    FN_RES_MEAS   = 4'h6,
    FN_DIN_LOGIC  = 4'h7,
    FN_DIN_LOOP   = 4'h8
  } cfr_func_t;

  typedef enum logic [2:0] {
    RG_0_10V      = 3'h0,
    RG_2V5_EXT    = 3'h1,
    RG_2V5_LOOP   = 3'h2,
    RG_BIPOLAR    = 3'h3
  } cfr_range_t;

  typedef enum logic [1:0] {
    IS_POS_GND    = 2'h0,
    IS_SENSE_RES  = 2'h1,
    IS_TERMINALS  = 2'h2
  } cfr_insel_t;

  typedef enum logic [1:0] {
    RT_REJECT_20  = 2'h0,
    RT_FAST_4K8   = 2'h1
  } cfr_rate_t;
endpackage
